//--- adcrm_defs.vh
`ifndef ADCRM_DEFS_VH
`define ADCRM_DEFS_VH
// register select codes
`define ADCRM_SEL_STATUS   4'h0
`define ADCRM_SEL_CONVERTER_CONTROL_FIRST    4'h1
`define ADCRM_SEL_PINS     4'h2
`define ADCRM_SEL_GAIN     4'h3
`define ADCRM_SEL_RESULT   4'h4
`define ADCRM_SEL_SYSZERO  4'h5
`define ADCRM_SEL_SYSSPAN  4'h6
`define ADCRM_SEL_SELFZERO 4'h7
`define ADCRM_SEL_SELFSPAN 4'h8
`define ADCRM_SEL_LAST     4'h8
// power-on values
`define ADCRM_RST_STATUS   8'h00
`define ADCRM_RST_CONVERTER_CONTROL_FIRST    8'h02
`define ADCRM_RST_PINS     8'h0F
`define ADCRM_RST_GAIN     8'h1E
`define ADCRM_RST_WIDE     24'h000000
// writable masks (reserved bits cleared)
`define ADCRM_MASK_CONVERTER_CONTROL_FIRST   8'hFE
`define ADCRM_MASK_PINS    8'hFF
`define ADCRM_MASK_GAIN    8'hFE
// command byte fields
`define ADCRM_CMD_START    7
`define ADCRM_CMD_MODE     6
`define ADCRM_CMD_ZERO     5
`define ADCRM_CMD_SEL_HI   4
`define ADCRM_CMD_SEL_LO   1
`define ADCRM_CMD_READ     0
// status bit positions
`define ADCRM_ST_CALOR     7
`define ADCRM_ST_RATE_HI   6
`define ADCRM_ST_RATE_LO   4
`define ADCRM_ST_OVER      3
`define ADCRM_ST_UNDER     2
`define ADCRM_ST_BUSY      1
`define ADCRM_ST_READY     0
// frame lengths in serial clocks
`define ADCRM_CMD_BITS     5'd8
`define ADCRM_NARROW_BITS  5'd8
`define ADCRM_WIDE_BITS    5'd24
`endif

//--- adcrm_sync.v
`timescale 1ns/10ps
// two-flop synchroniser for pins that arrive from outside
module adcrm_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_clk,
   input  wire             i_rst,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule // adcrm_sync

//--- adcrm_shift.v
`timescale 1ns/10ps
// msb-first shifter: bits enter on sclk rise, leave on sclk fall
module adcrm_shift (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_frame,
   input  wire        i_rise,
   input  wire        i_fall,
   input  wire        i_din,
   input  wire        i_load,
   input  wire [23:0] i_load_data,
   output wire [23:0] o_rx,
   output wire        o_tx
);
   reg [23:0] rx_q;
   reg [23:0] tx_q;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_q <= 24'h000000;
         tx_q <= 24'h000000;
      end else begin
         if (!i_frame)
            rx_q <= 24'h000000;
         else if (i_rise)
            rx_q <= {rx_q[22:0], i_din};
         if (i_load)
            tx_q <= i_load_data;
         else if (i_fall)
            tx_q <= {tx_q[22:0], 1'b0};
      end
   end
   assign o_rx = rx_q;
   assign o_tx = tx_q[23];
endmodule // adcrm_shift

//--- adcrm_regmap.v
`timescale 1ns/10ps
`include "adcrm_defs.vh"
// Overview of operation
// - decode select codes 0x0..0x8 to registers
// - read-only status register at code 0x0
// - first control register at code 0x1
// - pin direction and value register 0x2
// - gain and correction skip register 0x3
// - read-only 24-bit result at code 0x4
// - busy, ready, over/under flags in status
// - result shifted msb first, change on falls
module adcrm_regmap (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_cs_n,
   input  wire        i_sclk,
   input  wire        i_din,
   input  wire        i_conv_busy,
   input  wire        i_result_valid,
   input  wire [23:0] i_result,
   input  wire        i_over,
   input  wire        i_under,
   input  wire        i_cal_over,
   input  wire [2:0]  i_last_rate,
   input  wire [3:0]  i_pin_in,
   output reg         o_dout,
   output reg         o_dout_oe_n,
   output reg  [7:0]  o_converter_control_first,
   output reg  [3:0]  o_pin_dir,
   output reg  [3:0]  o_pin_value,
   output reg  [7:0]  o_gain_ctrl,
   output reg  [23:0] o_sys_zero,
   output reg  [23:0] o_sys_span,
   output reg  [23:0] o_self_zero,
   output reg  [23:0] o_self_span,
   output reg         o_result_read
);
   localparam ST_IDLE = 2'd0;
   localparam ST_CMD  = 2'd1;
   localparam ST_DATA = 2'd2;
   localparam ST_DONE = 2'd3;
   // pin register halves: direction in the high nibble, value in the low
   localparam [7:0] PINS_RST = `ADCRM_RST_PINS;

   wire        sel_s;
   wire        sclk_s;
   wire        din_s;
   wire [3:0]  pin_s;
   wire [23:0] rx;
   wire        tx;
   reg         sclk_q;
   reg  [1:0]  state_q;
   reg  [4:0]  cnt_q;
   reg  [4:0]  len_q;
   reg  [3:0]  sel_q;
   reg         rd_q;
   reg         load_q;
   reg  [23:0] load_data_q;
   reg  [23:0] result_q;
   reg         ready_q;
   reg  [7:0]  status;
   reg  [23:0] read_word;
   reg         sel_ok;
   reg         sel_wide;
   wire        frame;
   wire        rise;
   wire        fall;
   wire        cmd_ok;
   wire        cmd_last;
   wire        data_last;
   wire        wr_commit;
   wire [3:0]  pin_rd;
   genvar      g;

   // select enters inverted, so the synchroniser's cleared state means deselected
   adcrm_sync #(.WIDTH(7)) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async ({~i_cs_n, i_sclk, i_din, i_pin_in}),
      .o_sync  ({sel_s, sclk_s, din_s, pin_s})
   );

   assign frame = sel_s;
   assign rise  = frame & sclk_s & ~sclk_q;
   assign fall  = frame & ~sclk_s & sclk_q;

   adcrm_shift u_shift (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_frame     (frame),
      .i_rise      (rise),
      .i_fall      (fall),
      .i_din       (din_s),
      .i_load      (load_q),
      .i_load_data (load_data_q),
      .o_rx        (rx),
      .o_tx        (tx)
   );

   // command byte with the newest bit still arriving
   wire [7:0] cmd_byte = {rx[6:0], din_s};
   wire [3:0] cmd_sel  = cmd_byte[`ADCRM_CMD_SEL_HI:`ADCRM_CMD_SEL_LO];

   // only register-access command bytes are decoded here
   assign cmd_ok = cmd_byte[`ADCRM_CMD_START] & cmd_byte[`ADCRM_CMD_MODE] &
                   ~cmd_byte[`ADCRM_CMD_ZERO];

   assign cmd_last  = (cnt_q == `ADCRM_CMD_BITS - 5'd1);
   assign data_last = (cnt_q == len_q - 5'd1);
   // a write lands only on its final data rise; a frame cut short changes nothing
   assign wr_commit = rise & (state_q == ST_DATA) & ~rd_q & data_last;

   // outputs read back the stored level, inputs the pin itself
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pin_rd
         assign pin_rd[g] = o_pin_dir[g] ? o_pin_value[g] : pin_s[g];
      end
   endgenerate

   always @* begin
      status = 8'h00;
      status[`ADCRM_ST_CALOR] = i_cal_over;
      status[`ADCRM_ST_RATE_HI:`ADCRM_ST_RATE_LO] = i_last_rate;
      status[`ADCRM_ST_OVER]  = i_over;
      status[`ADCRM_ST_UNDER] = i_under;
      status[`ADCRM_ST_BUSY]  = i_conv_busy;
      status[`ADCRM_ST_READY] = ready_q;
   end

   always @* begin
      sel_ok    = 1'b1;
      sel_wide  = 1'b0;
      read_word = 24'h000000;
      case (cmd_sel)
         `ADCRM_SEL_STATUS: begin
            read_word = {status, 16'h0000};
         end
         `ADCRM_SEL_CONVERTER_CONTROL_FIRST: begin
            read_word = {o_converter_control_first & `ADCRM_MASK_CONVERTER_CONTROL_FIRST, 16'h0000};
         end
         `ADCRM_SEL_PINS: begin
            read_word = {o_pin_dir, pin_rd, 16'h0000};
         end
         `ADCRM_SEL_GAIN: begin
            read_word = {o_gain_ctrl & `ADCRM_MASK_GAIN, 16'h0000};
         end
         `ADCRM_SEL_RESULT: begin
            sel_wide  = 1'b1;
            read_word = result_q;
         end
         `ADCRM_SEL_SYSZERO: begin
            sel_wide  = 1'b1;
            read_word = o_sys_zero;
         end
         `ADCRM_SEL_SYSSPAN: begin
            sel_wide  = 1'b1;
            read_word = o_sys_span;
         end
         `ADCRM_SEL_SELFZERO: begin
            sel_wide  = 1'b1;
            read_word = o_self_zero;
         end
         `ADCRM_SEL_SELFSPAN: begin
            sel_wide  = 1'b1;
            read_word = o_self_span;
         end
         default: begin
            sel_ok = 1'b0;
         end
      endcase
   end

   // a new result sets ready; the set wins over a clear by readout
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         result_q <= `ADCRM_RST_WIDE;
         ready_q  <= 1'b0;
      end else if (i_result_valid) begin
         result_q <= i_result;
         ready_q  <= 1'b1;
      end else if (o_result_read) begin
         ready_q  <= 1'b0;
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_converter_control_first     <= `ADCRM_RST_CONVERTER_CONTROL_FIRST;
         o_pin_dir   <= PINS_RST[7:4];
         o_pin_value <= PINS_RST[3:0];
         o_gain_ctrl <= `ADCRM_RST_GAIN;
         o_sys_zero  <= `ADCRM_RST_WIDE;
         o_sys_span  <= `ADCRM_RST_WIDE;
         o_self_zero <= `ADCRM_RST_WIDE;
         o_self_span <= `ADCRM_RST_WIDE;
      end else if (wr_commit) begin
         // rx kept shifting through the data phase, so its low bits hold the word
         case (sel_q)
            `ADCRM_SEL_CONVERTER_CONTROL_FIRST: begin
               o_converter_control_first <= {rx[6:0], din_s} & `ADCRM_MASK_CONVERTER_CONTROL_FIRST;
            end
            `ADCRM_SEL_PINS: begin
               o_pin_dir   <= rx[6:3];
               o_pin_value <= {rx[2:0], din_s};
            end
            `ADCRM_SEL_GAIN: begin
               o_gain_ctrl <= {rx[6:0], din_s} & `ADCRM_MASK_GAIN;
            end
            `ADCRM_SEL_SYSZERO: begin
               o_sys_zero <= {rx[22:0], din_s};
            end
            `ADCRM_SEL_SYSSPAN: begin
               o_sys_span <= {rx[22:0], din_s};
            end
            `ADCRM_SEL_SELFZERO: begin
               o_self_zero <= {rx[22:0], din_s};
            end
            `ADCRM_SEL_SELFSPAN: begin
               o_self_span <= {rx[22:0], din_s};
            end
            default: begin
               // status and result are read-only: the write is dropped
            end
         endcase
      end
   end

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_q        <= 1'b0;
         state_q       <= ST_IDLE;
         cnt_q         <= 5'd0;
         len_q         <= 5'd0;
         sel_q         <= 4'h0;
         rd_q          <= 1'b0;
         load_q        <= 1'b0;
         load_data_q   <= 24'h000000;
         o_dout        <= 1'b1;
         o_dout_oe_n   <= 1'b1;
         o_result_read <= 1'b0;
      end else begin
         sclk_q        <= sclk_s;
         load_q        <= 1'b0;
         o_result_read <= 1'b0;
         o_dout_oe_n   <= ~frame;
         if (!frame) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'd0;
            o_dout  <= 1'b1;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  state_q <= ST_CMD;
                  // low dout signals a waiting result during the command byte
                  o_dout  <= ~ready_q;
               end
               ST_CMD: begin
                  if (fall)
                     o_dout <= ~ready_q;
                  if (rise) begin
                     cnt_q <= cnt_q + 5'd1;
                     // the read word loads one edge later, long before the first fall
                     if (cmd_last) begin
                        cnt_q <= 5'd0;
                        if (cmd_ok && sel_ok) begin
                           state_q     <= ST_DATA;
                           sel_q       <= cmd_sel;
                           rd_q        <= cmd_byte[`ADCRM_CMD_READ];
                           len_q       <= sel_wide ? `ADCRM_WIDE_BITS : `ADCRM_NARROW_BITS;
                           load_q      <= 1'b1;
                           load_data_q <= read_word;
                        end else begin
                           state_q <= ST_DONE;
                        end
                     end
                  end
               end
               ST_DATA: begin
                  if (fall && rd_q)
                     o_dout <= tx;
                  if (rise) begin
                     cnt_q <= cnt_q + 5'd1;
                     if (data_last) begin
                        state_q <= ST_DONE;
                        if (rd_q && sel_q == `ADCRM_SEL_RESULT)
                           o_result_read <= 1'b1;
                     end
                  end
               end
               ST_DONE: begin
                  o_dout <= 1'b1;
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // adcrm_regmap

//--- adcrm_chk_assertions.sv
`timescale 1ns/10ps
module adcrm_chk (
   input wire        i_clk,
   input wire        i_rst,
   input wire        i_cs_n,
   input wire        i_result_valid,
   input wire        o_dout,
   input wire        o_dout_oe_n,
   input wire [7:0]  o_converter_control_first,
   input wire [3:0]  o_pin_dir,
   input wire [7:0]  o_gain_ctrl,
   input wire [23:0] o_sys_zero,
   input wire        o_result_read
);
   reg rdy_q;
   // shadow of the ready flag: new result wins over a finished read
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) rdy_q <= 1'b0;
      else if (i_result_valid) rdy_q <= 1'b1;
      else if (o_result_read) rdy_q <= 1'b0;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence frame_start;
      $fell(o_dout_oe_n) ##1 1'b1;
   endsequence
   sequence frame_end;
      $rose(i_cs_n);
   endsequence
   a_ready_shown: assert property (frame_start |-> o_dout == !rdy_q)
      else $error("dout does not show ready at frame start");
   a_oe_release: assert property (frame_end |-> ##[1:4] o_dout_oe_n)
      else $error("dout enable not released after select");
   a_dout_idle: assert property (o_dout_oe_n |-> o_dout)
      else $error("dout not high outside frame");
   a_converter_control_first_resv: assert property (o_converter_control_first[0] == 1'b0)
      else $error("first control reserved bit set");
   a_gain_resv: assert property (o_gain_ctrl[0] == 1'b0)
      else $error("gain reserved bit set");
   a_write_inframe: assert property
      (!$stable({o_converter_control_first, o_pin_dir, o_gain_ctrl, o_sys_zero}) |-> !o_dout_oe_n)
      else $error("register changed outside a frame");
   a_read_pulse: assert property (o_result_read |=> !o_result_read)
      else $error("result read pulse too long");
   a_read_inframe: assert property (o_result_read |-> !o_dout_oe_n)
      else $error("result read pulse outside frame");
endmodule // adcrm_chk
bind adcrm_regmap adcrm_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
   .i_result_valid(i_result_valid), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
   .o_converter_control_first(o_converter_control_first), .o_pin_dir(o_pin_dir), .o_gain_ctrl(o_gain_ctrl),
   .o_sys_zero(o_sys_zero), .o_result_read(o_result_read));

//--- adcrm_host.sv
`timescale 1ns/10ps
module adcrm_host (
   input  wire i_clk,
   input  wire i_dout,
   output reg  o_cs_n,
   output reg  o_sclk,
   output reg  o_din
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din  = 1'b0;
   end
   task automatic half;
      begin
         repeat (6) @(posedge i_clk);
         #1;
      end
   endtask
   // command byte then n data bits; fewer than the width aborts
   task automatic xfer(input [7:0] cmd, input [23:0] wd, input integer n,
                       output [23:0] rd);
      integer    i;
      reg [31:0] sh;
      begin
         // data bits beyond the frame length must not spill into the command byte
         sh = {cmd, 24'h000000} | (({8'h00, wd} << (24 - n)) & 32'h00FFFFFF);
         rd = 24'h000000;
         o_cs_n = 1'b0;
         for (i = 0; i < 8 + n; i = i + 1) begin
            o_din = sh[31 - i];
            half;
            if (i >= 8) rd = {rd[22:0], i_dout};
            o_sclk = 1'b1;
            half;
            o_sclk = 1'b0;
         end
         half;
         o_cs_n = 1'b1;
         o_din  = ~o_din;
         half;
      end
   endtask
endmodule // adcrm_host

//--- adcrm_regmap_test.sv
`timescale 1ns/10ps
module adcrm_regmap_test;
   reg         i_clk = 1'b0, i_rst = 1'b1, busy = 1'b0, valid = 1'b0;
   reg         over = 1'b0, under = 1'b0, cal_over = 1'b0;
   reg  [2:0]  rate = 3'h0;
   reg  [3:0]  pin_in = 4'h0;
   reg  [23:0] result = 24'h000000, v;
   reg  [31:0] lf = 32'hB5DF;
   reg  [23:0] mdl [0:8];
   integer     rdy = 0, checked = 0, bad_count = 0, c;
   wire        cs_n, sclk, din, dout, oe_n, result_read;
   wire [7:0]  converter_control_first, gain;
   wire [3:0]  pdir, pval;
   wire [23:0] sz, ss, fz, fs;
   always #25 i_clk = ~i_clk;
   adcrm_host host_u (.i_clk(i_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
   adcrm_regmap dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_din(din), .i_conv_busy(busy), .i_result_valid(valid), .i_result(result),
      .i_over(over), .i_under(under), .i_cal_over(cal_over), .i_last_rate(rate),
      .i_pin_in(pin_in), .o_dout(dout), .o_dout_oe_n(oe_n), .o_converter_control_first(converter_control_first),
      .o_pin_dir(pdir), .o_pin_value(pval), .o_gain_ctrl(gain), .o_sys_zero(sz),
      .o_sys_span(ss), .o_self_zero(fz), .o_self_span(fs), .o_result_read(result_read));
   function [31:0] nxt(input [31:0] x);
      nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function [23:0] expv(input integer k);
      case (k)
         0: expv = {16'h0000, cal_over, rate, over, under, busy, rdy[0]};
         2: expv = {16'h0000, mdl[2][7:4], (mdl[2][3:0] & mdl[2][7:4]) | (pin_in & ~mdl[2][7:4])};
         default: expv = mdl[k];
      endcase
   endfunction
   task chk(input [23:0] got, input [23:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task rd(input integer k);
      begin
         host_u.xfer({3'b110, k[3:0], 1'b1}, 24'h000000, k > 3 ? 24 : 8, v);
         chk(v, expv(k));
         if (k == 4) rdy = 0;
      end
   endtask
   task rd_all;
      begin
         for (c = 0; c < 9; c = c + 1) rd(c);
         chk({16'h0000, converter_control_first}, mdl[1]);
         chk({16'h0000, pdir, pval}, mdl[2]);
         chk({16'h0000, gain}, mdl[3]);
         chk(sz, mdl[5]);
         chk(ss, mdl[6]);
         chk(fz, mdl[7]);
         chk(fs, mdl[8]);
      end
   endtask
   task stir;
      begin
         @(posedge i_clk) #1;
         lf = nxt(lf);
         {cal_over, rate, over, under, busy, pin_in} = lf[10:0];
      end
   endtask
   task close_out;
      begin
         $display("checked=%0d bad_count=%0d", checked, bad_count);
         if (bad_count == 0 && checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      mdl[0] = 0; mdl[1] = 24'h02; mdl[2] = 24'h0F; mdl[3] = 24'h1E;
      for (c = 4; c < 9; c = c + 1) mdl[c] = 0;
      repeat (10) @(posedge i_clk);
      #1 i_rst = 1'b0;
      rd_all;
      $display("test power-on values done");
      for (c = 0; c < 9; c = c + 1) begin
         stir;
         host_u.xfer({3'b110, c[3:0], 1'b0}, lf[30:7], c > 3 ? 24 : 8, v);
         if (c == 1 || c == 3) mdl[c] = {16'h0000, lf[14:8], 1'b0};
         else if (c == 2) mdl[c] = {16'h0000, lf[14:7]};
         else if (c > 4) mdl[c] = lf[30:7];
      end
      rd_all;
      $display("test write and readback done");
      stir;
      valid = 1'b1;
      result = lf[31:8];
      @(posedge i_clk) #1 valid = 1'b0;
      mdl[4] = result;
      rdy = 1;
      rd(0);
      rd(4);
      rd(0);
      $display("test result read done");
      host_u.xfer(8'hE3, 24'h000000, 24, v);
      chk(v, 24'hFFFFFF);
      host_u.xfer(8'hD3, 24'h000000, 24, v);
      chk(v, 24'hFFFFFF);
      host_u.xfer(8'h43, 24'h000000, 24, v);
      chk(v, 24'hFFFFFF);
      host_u.xfer(8'hC6, 24'h00000F, 4, v);
      chk({22'h000000, oe_n, dout}, 24'h000003);
      rd_all;
      $display("test refused and aborted frames done");
      close_out;
   end
endmodule // adcrm_regmap_test
